// >>> core/smbus_config_timeout.sv
// module: configuration register, bus supervision and timeout control of the two-wire interface
`timescale 1ns/1ps

module smbus_config_timeout (
  // system clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // link sampling clock, free running
  input wire logic link_clk,
  // bus pins, input side only; this block never drives them
  input wire logic scl_in,
  input wire logic sda_in,
  // special-function register access
  input wire smbus_cfg_pkg::sfr_req_t sfr_req,
  output logic [7:0] sfr_rdata,
  // timer overflow strobes and timer three mode
  input wire smbus_cfg_pkg::timer_ovf_t timer_ovf,
  input wire logic timer3_split,
  output logic timer3_high_reload,
  output logic timer3_low_reload,
  // events to and from the transfer sequencer
  input wire logic master_event,
  input wire logic slave_event,
  input wire logic start_pending,
  output logic serial_irq,
  output logic slave_nack_force,
  output logic master_start_go,
  // state toward the sequencer and shifter
  output logic interface_enable,
  output logic bit_clock_strobe,
  output logic bus_busy,
  output logic bus_free_timeout,
  output logic comm_reset,
  output logic [3:0] sda_setup_cycles,
  output logic [3:0] sda_hold_cycles,
  output logic sda_hold_done
);

  // link-domain state: pin synchronisers and start/stop toggles
  typedef struct packed {
    logic scl_meta;
    logic scl_sync;
    logic sda_meta;
    logic sda_sync;
    logic scl_prev;
    logic sda_prev;
    logic scl_high;
    logic bus_high;
    logic start_tgl;
    logic stop_tgl;
  } link_state_t;

  // system-domain state
  typedef struct packed {
    smbus_cfg_pkg::bus_configuration_t cfg;
    logic [7:0] rdata;
    logic inhibit_active;
    logic [3:0] free_cnt;
    logic free_hit;
    logic start_go;
    logic irq;
    logic t3_high_reload;
    logic t3_low_reload;
    logic [3:0] setup_cyc;
    logic [3:0] hold_cyc;
    logic [3:0] hold_cnt;
    logic hold_done;
    logic comm_reset;
  } sys_state_t;

  link_state_t lq;
  link_state_t ld;
  sys_state_t q;
  sys_state_t d;

  // crossing lanes, source side and system side
  logic [smbus_cfg_pkg::X_WIDTH-1:0] x_src;
  logic [smbus_cfg_pkg::X_WIDTH-1:0] x_lvl;
  logic [smbus_cfg_pkg::X_WIDTH-1:0] x_chg;

  // decode and selected overflow strobe
  logic sfr_hit;
  logic bit_stb;

  // ---------------- link domain ----------------

  // pins pass two flops; start/stop judged only on the settled stage
  always_comb begin
    ld = lq;
    ld.scl_meta = scl_in;
    ld.scl_sync = lq.scl_meta;
    ld.sda_meta = sda_in;
    ld.sda_sync = lq.sda_meta;
    ld.scl_prev = lq.scl_sync;
    ld.sda_prev = lq.sda_sync;
    ld.scl_high = lq.scl_sync;
    // one flop holds the and, so the crossing never sees a glitch
    ld.bus_high = lq.scl_sync & lq.sda_sync;
    // sda falling while scl stays high: start condition
    if (lq.scl_sync && lq.scl_prev && lq.sda_prev && !lq.sda_sync) begin
      ld.start_tgl = ~lq.start_tgl;
    end
    // sda rising while scl stays high: stop condition
    if (lq.scl_sync && lq.scl_prev && !lq.sda_prev && lq.sda_sync) begin
      ld.stop_tgl = ~lq.stop_tgl;
    end
  end

  // idle bus is high on both lines, so the samplers reset to one
  always_ff @(posedge link_clk or negedge nrst) begin
    if (!nrst) begin
      lq <= '{
        scl_meta: 1'b1,
        scl_sync: 1'b1,
        sda_meta: 1'b1,
        sda_sync: 1'b1,
        scl_prev: 1'b1,
        sda_prev: 1'b1,
        scl_high: 1'b1,
        bus_high: 1'b1,
        start_tgl: 1'b0,
        stop_tgl: 1'b0
      };
    end else begin
      lq <= ld;
    end
  end

  // ---------------- crossing ----------------

  // events travel as toggles, levels as levels, all through two flops
  always_comb begin
    x_src = '0;
    x_src[smbus_cfg_pkg::X_SCL_HIGH] = lq.scl_high;
    x_src[smbus_cfg_pkg::X_BUS_HIGH] = lq.bus_high;
    x_src[smbus_cfg_pkg::X_START] = lq.start_tgl;
    x_src[smbus_cfg_pkg::X_STOP] = lq.stop_tgl;
  end

  level_crossing #(
    .W(smbus_cfg_pkg::X_WIDTH)
  ) u_link_to_sys (
    .dst_clk(sys_clk),
    .nrst(nrst),
    .src_lvl(x_src),
    .lvl(x_lvl),
    .chg(x_chg)
  );

  // ---------------- system domain ----------------

  // register decode on address and page together
  assign sfr_hit = (sfr_req.addr == smbus_cfg_pkg::CFG_SFR_ADDR) &&
                   (sfr_req.page == smbus_cfg_pkg::CFG_SFR_PAGE);

  // overflow strobe that paces the bit rate and the free timeout
  always_comb begin
    case (q.cfg.bit_clock_source_select)
      smbus_cfg_pkg::CS_TIMER0: begin
        bit_stb = timer_ovf.timer0;
      end
      smbus_cfg_pkg::CS_TIMER1: begin
        bit_stb = timer_ovf.timer1;
      end
      smbus_cfg_pkg::CS_TIMER2_HIGH: begin
        bit_stb = timer_ovf.timer2_high;
      end
      smbus_cfg_pkg::CS_TIMER2_LOW: begin
        bit_stb = timer_ovf.timer2_low;
      end
      default: begin
        bit_stb = timer_ovf.timer0;
      end
    endcase
  end

  always_comb begin
    logic start_seen;
    logic stop_seen;
    logic scl_high;
    logic bus_high;
    logic scl_fell;
    logic free_now;
    logic free_armed;
    logic cfg_wr;
    logic cfg_rd;
    logic busy_clr;
    logic busy_set;
    logic master_irq;
    logic slave_irq;
    logic scl_gate;
    start_seen = 1'b0;
    stop_seen = 1'b0;
    scl_high = 1'b0;
    bus_high = 1'b0;
    scl_fell = 1'b0;
    free_now = 1'b0;
    free_armed = 1'b0;
    cfg_wr = 1'b0;
    cfg_rd = 1'b0;
    busy_clr = 1'b0;
    busy_set = 1'b0;
    master_irq = 1'b0;
    slave_irq = 1'b0;
    scl_gate = 1'b0;
    d = q;

    start_seen = x_chg[smbus_cfg_pkg::X_START];
    stop_seen = x_chg[smbus_cfg_pkg::X_STOP];
    scl_high = x_lvl[smbus_cfg_pkg::X_SCL_HIGH];
    bus_high = x_lvl[smbus_cfg_pkg::X_BUS_HIGH];
    scl_fell = x_chg[smbus_cfg_pkg::X_SCL_HIGH] & ~scl_high;

    // access strobes of this register only
    cfg_wr = sfr_hit && sfr_req.wr;
    cfg_rd = sfr_hit && sfr_req.rd;

    // software write; busy is hardware-owned and keeps its value
    if (cfg_wr) begin
      d.cfg = smbus_cfg_pkg::bus_configuration_t'(sfr_req.wdata);
      d.cfg.busy = q.cfg.busy;
    end

    // a falling enable tells the sequencer to drop the transfer
    d.comm_reset = q.cfg.interface_enable & ~d.cfg.interface_enable;

    // free timeout: count selected overflows while both lines stay high
    free_armed = q.cfg.interface_enable && q.cfg.bus_free_timeout_enable && bus_high;
    if (!free_armed) begin
      d.free_cnt = smbus_cfg_pkg::FREE_CNT_CLEAR;
    end else if (bit_stb && q.free_cnt != smbus_cfg_pkg::FREE_CNT_LIMIT) begin
      d.free_cnt = 4'(q.free_cnt + smbus_cfg_pkg::FREE_CNT_STEP);
    end
    // the eleventh overflow is the first that exceeds ten periods
    free_now = free_armed && bit_stb &&
               (q.free_cnt == smbus_cfg_pkg::FREE_TIMEOUT_PERIODS);
    d.free_hit = free_now;
    d.start_go = free_now & start_pending;

    // busy: clears on stop or free timeout, a start in the same cycle wins
    busy_clr = stop_seen || free_now;
    busy_set = start_seen;
    if (!d.cfg.interface_enable) begin
      d.cfg.busy = 1'b0;
    end else begin
      if (busy_clr) begin
        d.cfg.busy = 1'b0;
      end
      if (busy_set) begin
        d.cfg.busy = 1'b1;
      end
    end

    // while enabled, inhibit is taken over only at a start, so the current transfer finishes; while disabled it follows the bit
    if (!q.cfg.interface_enable) begin
      d.inhibit_active = q.cfg.slave_inhibit;
    end else if (start_seen) begin
      d.inhibit_active = q.cfg.slave_inhibit;
    end

    // while enabled, master events always pass; slave events only when not inhibited
    master_irq = master_event;
    slave_irq = slave_event & ~q.inhibit_active;
    d.irq = q.cfg.interface_enable & (master_irq | slave_irq);

    // timer three follows scl; split mode frees the low byte
    scl_gate = q.cfg.scl_low_timeout_enable & scl_high;
    d.t3_high_reload = scl_gate;
    d.t3_low_reload = scl_gate & ~timer3_split;

    // setup and hold minimums from the extension bit
    if (q.cfg.sda_timing_extend) begin
      d.setup_cyc = smbus_cfg_pkg::SETUP_EXT_CYC;
      d.hold_cyc = smbus_cfg_pkg::HOLD_EXT_CYC;
    end else begin
      d.setup_cyc = smbus_cfg_pkg::SETUP_NORM_CYC;
      d.hold_cyc = smbus_cfg_pkg::HOLD_NORM_CYC;
    end

    // hold window after scl falls; crossing delay only lengthens it
    if (scl_fell) begin
      d.hold_cnt = d.hold_cyc;
    end else if (q.hold_cnt != smbus_cfg_pkg::HOLD_DONE_CNT) begin
      d.hold_cnt = 4'(q.hold_cnt - 4'h1);
    end
    d.hold_done = (d.hold_cnt == smbus_cfg_pkg::HOLD_DONE_CNT);

    // read answers one cycle later; unmatched reads return zero
    if (sfr_req.rd) begin
      d.rdata = cfg_rd ? q.cfg : smbus_cfg_pkg::CFG_RESET;
    end
  end

  // all fields clear except hold_done, which resets to one, so the interface starts disabled on timer zero
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      q <= '0;
      q.hold_done <= 1'b1;
    end else begin
      q <= d;
    end
  end

  // outputs straight from flops, apart from the strobe mux and the nack gate
  assign sfr_rdata = q.rdata;

  // timer three reload controls
  assign timer3_high_reload = q.t3_high_reload;
  assign timer3_low_reload = q.t3_low_reload;

  // events toward the sequencer
  assign serial_irq = q.irq;
  assign slave_nack_force = q.cfg.interface_enable & q.inhibit_active;
  assign master_start_go = q.start_go;

  // configuration and supervision state
  assign interface_enable = q.cfg.interface_enable;
  assign bit_clock_strobe = bit_stb;
  assign bus_busy = q.cfg.busy;
  assign bus_free_timeout = q.free_hit;
  assign comm_reset = q.comm_reset;

  // sda timing toward the shifter
  assign sda_setup_cycles = q.setup_cyc;
  assign sda_hold_cycles = q.hold_cyc;
  assign sda_hold_done = q.hold_done;

endmodule

// >>> core/smbus_cfg_pkg.sv
// package: register map, field layout, carriers and timing constants of the bus configuration block
package smbus_cfg_pkg;

  // configuration register location in the special-function space
  localparam logic [7:0] CFG_SFR_ADDR = 8'hC1;
  localparam logic [7:0] CFG_SFR_PAGE = 8'h00;
  localparam logic [7:0] CFG_RESET = 8'h00;

  // bit clock source encodings
  localparam logic [1:0] CS_TIMER0 = 2'h0;
  localparam logic [1:0] CS_TIMER1 = 2'h1;
  localparam logic [1:0] CS_TIMER2_HIGH = 2'h2;
  localparam logic [1:0] CS_TIMER2_LOW = 2'h3;

  // sda setup and hold minimums, in system clocks
  localparam logic [3:0] SETUP_NORM_CYC = 4'h1;
  localparam logic [3:0] HOLD_NORM_CYC = 4'h3;
  localparam logic [3:0] SETUP_EXT_CYC = 4'hB;
  localparam logic [3:0] HOLD_EXT_CYC = 4'hC;
  localparam logic [3:0] HOLD_DONE_CNT = 4'h0;

  // bus free: strictly more than this many source periods high
  localparam logic [3:0] FREE_TIMEOUT_PERIODS = 4'hA;
  localparam logic [3:0] FREE_CNT_LIMIT = 4'(FREE_TIMEOUT_PERIODS + 4'h1);
  localparam logic [3:0] FREE_CNT_CLEAR = 4'h0;
  localparam logic [3:0] FREE_CNT_STEP = 4'h1;

  // lanes of the link-to-system crossing
  localparam int X_SCL_HIGH = 0;
  localparam int X_BUS_HIGH = 1;
  localparam int X_START = 2;
  localparam int X_STOP = 3;
  localparam int X_WIDTH = 4;

  // configuration register, msb first as it reads on the bus
  typedef struct packed {
    logic interface_enable;
    logic slave_inhibit;
    logic busy;
    logic sda_timing_extend;
    logic scl_low_timeout_enable;
    logic bus_free_timeout_enable;
    logic [1:0] bit_clock_source_select;
  } bus_configuration_t;

  // one special-function access cycle
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] page;
    logic wr;
    logic rd;
    logic [7:0] wdata;
  } sfr_req_t;

  // overflow strobes of the candidate timers
  typedef struct packed {
    logic timer0;
    logic timer1;
    logic timer2_high;
    logic timer2_low;
  } timer_ovf_t;

endpackage

// >>> core/level_crossing.sv
// module: two-flop crossing of levels and toggles into the destination clock domain
`timescale 1ns/1ps

module level_crossing #(
  parameter int W = 4
) (
  // destination clock and reset
  input wire logic dst_clk,
  input wire logic nrst,
  // levels or toggles from the source domain, each from a flop there
  input wire logic [W-1:0] src_lvl,
  // synchronised level and one-cycle change pulse
  output logic [W-1:0] lvl,
  output logic [W-1:0] chg
);

  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] sync;
    logic [W-1:0] prev;
  } xstate_t;

  xstate_t q;
  xstate_t d;

  // meta stage feeds only the sync stage; edge logic looks at later stages
  always_comb begin
    d = q;
    d.meta = src_lvl;
    d.sync = q.meta;
    d.prev = q.sync;
  end

  always_ff @(posedge dst_clk or negedge nrst) begin
    if (!nrst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign lvl = q.sync;
  assign chg = q.sync ^ q.prev;

endmodule

// >>> tb/smbus_far_end.sv
// far-side bus device: drives clock and data levels on the shared wires
`timescale 1ns/1ps

module smbus_far_end (
  // paces every pin change
  input wire logic link_clk,
  // wire levels, pulled high when released
  output logic scl,
  output logic sda
);
  initial begin
    scl = 1'b1;
    sda = 1'b1;
  end
  // four link clocks per level so the two-sample filter always sees it
  task automatic step(input logic c, input logic d);
    repeat (4) @(posedge link_clk);
    scl <= c;
    sda <= d;
  endtask
  // data falls while clock high, then clock drops
  task automatic start_cond();
    step(1'b1, 1'b0);
    step(1'b0, 1'b0);
  endtask
  // clock rises, then data rises while clock high
  task automatic stop_cond();
    step(1'b1, 1'b0);
    step(1'b1, 1'b1);
  endtask
  // back to idle high without a stop: data moves while clock low
  task automatic release_high();
    step(1'b0, 1'b1);
    step(1'b1, 1'b1);
  endtask
endmodule

// >>> tb/smbus_config_timeout_asserts.sv
// checker: port-level properties of the bus configuration block
`timescale 1ns/1ps

module smbus_config_timeout_asserts (
  // clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // register access
  input wire smbus_cfg_pkg::sfr_req_t sfr_req,
  input wire logic [7:0] sfr_rdata,
  // timers
  input wire smbus_cfg_pkg::timer_ovf_t timer_ovf,
  input wire logic timer3_split,
  input wire logic timer3_high_reload,
  input wire logic timer3_low_reload,
  // events
  input wire logic master_event,
  input wire logic start_pending,
  input wire logic serial_irq,
  input wire logic slave_nack_force,
  input wire logic master_start_go,
  // state
  input wire logic interface_enable,
  input wire logic bit_clock_strobe,
  input wire logic bus_free_timeout,
  input wire logic [3:0] sda_setup_cycles,
  input wire logic [3:0] sda_hold_cycles
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);

  // a read aimed at any address but the register's, whatever the page
  sequence s_stray_rd;
    sfr_req.rd && sfr_req.addr != smbus_cfg_pkg::CFG_SFR_ADDR;
  endsequence

  a_unmapped_read: assert property (s_stray_rd |=> sfr_rdata == 8'h00)
    else $error("stray read gave data");
  a_strobe_source: assert property (bit_clock_strobe |-> |timer_ovf)
    else $error("strobe without overflow");
  a_split_reload: assert property (
    timer3_low_reload |-> timer3_high_reload && !$past(timer3_split))
    else $error("low byte reloaded in split mode");
  a_master_irq: assert property (interface_enable && master_event |=> serial_irq)
    else $error("master event lost");
  a_irq_off: assert property (!interface_enable |=> !serial_irq)
    else $error("irq while disabled");
  a_nack_enabled: assert property (slave_nack_force |-> interface_enable)
    else $error("nack while disabled");
  a_ext_timing: assert property (
    (sda_hold_cycles == 4'hC) == (sda_setup_cycles == 4'hB))
    else $error("extended setup and hold disagree");
  a_norm_timing: assert property (sda_setup_cycles == 4'h1 |-> sda_hold_cycles == 4'h3)
    else $error("normal hold wrong");
  a_go_after_free: assert property (
    master_start_go |-> bus_free_timeout && $past(start_pending))
    else $error("start without free timeout");
  a_free_strobe: assert property (
    bus_free_timeout |-> $past(bit_clock_strobe) || $past(bit_clock_strobe, 2))
    else $error("free timeout without strobe");
endmodule

bind smbus_config_timeout smbus_config_timeout_asserts u_chk (
  .sys_clk(sys_clk), .nrst(nrst), .sfr_req(sfr_req), .sfr_rdata(sfr_rdata),
  .timer_ovf(timer_ovf), .timer3_split(timer3_split), .timer3_high_reload(timer3_high_reload),
  .timer3_low_reload(timer3_low_reload), .master_event(master_event),
  .start_pending(start_pending), .serial_irq(serial_irq), .slave_nack_force(slave_nack_force),
  .master_start_go(master_start_go), .interface_enable(interface_enable),
  .bit_clock_strobe(bit_clock_strobe), .bus_free_timeout(bus_free_timeout),
  .sda_setup_cycles(sda_setup_cycles), .sda_hold_cycles(sda_hold_cycles)
);

// >>> tb/tb_top.sv
// testbench: register access, bus watch, timeouts and event gating
`timescale 1ns/1ps

module tb_top;
  logic sys_clk = 1'b0;
  logic link_clk = 1'b0;
  logic nrst, scl, sda, split, m_ev, s_ev, pend;
  logic irq, nack, go, en, stb, busy, free, crst, rl_hi, rl_lo, hold_ok;
  logic [7:0] rdata;
  logic [3:0] setup, hold;
  smbus_cfg_pkg::sfr_req_t req;
  smbus_cfg_pkg::timer_ovf_t ovf;
  logic [7:0] exp_q[$];
  int miscompares = 0;
  int n_tests = 0;
  int n_free = 0;
  int n_go = 0;
  int n_rst = 0;
  int n_hold = 0;
  int seed = 11519;

  // 50 MHz system clock
  always #10 sys_clk = ~sys_clk;
  // link clock offset so its edges drift against the system clock
  initial begin
    #1.7;
    forever #3 link_clk = ~link_clk;
  end

  smbus_far_end far (.link_clk(link_clk), .scl(scl), .sda(sda));

  smbus_config_timeout dut (
    .sys_clk(sys_clk), .nrst(nrst), .link_clk(link_clk), .scl_in(scl), .sda_in(sda),
    .sfr_req(req), .sfr_rdata(rdata), .timer_ovf(ovf), .timer3_split(split),
    .timer3_high_reload(rl_hi), .timer3_low_reload(rl_lo), .master_event(m_ev),
    .slave_event(s_ev), .start_pending(pend), .serial_irq(irq), .slave_nack_force(nack),
    .master_start_go(go), .interface_enable(en), .bit_clock_strobe(stb), .bus_busy(busy),
    .bus_free_timeout(free), .comm_reset(crst), .sda_setup_cycles(setup),
    .sda_hold_cycles(hold), .sda_hold_done(hold_ok)
  );

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic final_report();
    if (miscompares == 0 && n_tests > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // one register cycle; for reads, the rd task queues the expectation before calling this
  task automatic sfr(input logic w, input logic [7:0] a, input logic [7:0] p,
                     input logic [7:0] d);
    @(negedge sys_clk);
    req = '{addr: a, page: p, wr: w, rd: !w, wdata: d};
    @(negedge sys_clk);
    req.wr = 1'b0;
    req.rd = 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] p, input logic [7:0] e);
    exp_q.push_back(e);
    sfr(1'b0, a, p, 8'h00);
  endtask

  task automatic idle(input int n);
    repeat (n) @(negedge sys_clk);
  endtask

  task automatic tick(input int n);
    repeat (n) begin
      @(negedge sys_clk);
      ovf = 4'h8;
      @(negedge sys_clk);
      ovf = 4'h0;
    end
  endtask

  // read data lands one edge after the read cycle
  always @(posedge sys_clk) begin
    if (req.rd === 1'b1) begin
      #1;
      check(rdata, exp_q.pop_front());
    end
  end

  // pulse counters
  always @(posedge sys_clk) begin
    n_free += int'(free === 1'b1);
    n_go += int'(go === 1'b1);
    n_rst += int'(crst === 1'b1);
    n_hold += int'(nrst === 1'b1 && hold_ok === 1'b0);
  end

  initial begin
    #100us;
    miscompares++;
    final_report();
  end

  initial begin
    nrst = 1'b0;
    req = '0;
    ovf = '0;
    {split, m_ev, s_ev, pend} = 4'h0;
    repeat (2) @(posedge sys_clk);
    @(negedge sys_clk);
    nrst = 1'b1;
    rd(8'hC1, 8'h00, 8'h00);
    sfr(1'b1, 8'hC1, 8'h00, 8'hFF);
    rd(8'hC1, 8'h00, 8'hDF);
    check({setup, hold}, 8'hBC);
    rd(8'hC0, 8'h00, 8'h00);
    rd(8'hC1, 8'h01, 8'h00);
    // every source code against random overflow patterns
    for (int i = 0; i < 4; i++) begin
      sfr(1'b1, 8'hC1, 8'h00, 8'(8'h80 + i));
      repeat (3) begin
        @(negedge sys_clk);
        ovf = 4'($random(seed));
        #1 check(8'(stb), 8'(ovf[3 - i]));
      end
    end
    ovf = '0;
    s_ev = 1'b1;
    sfr(1'b1, 8'hC1, 8'h00, 8'hC4);
    idle(2);
    check(8'(irq), 8'h01);
    far.start_cond();
    idle(8);
    check({busy, irq, nack}, 8'h05);
    rd(8'hC1, 8'h00, 8'hE4);
    m_ev = 1'b1;
    idle(2);
    check(8'(irq), 8'h01);
    {m_ev, s_ev} = 2'b00;
    far.release_high();
    idle(8);
    pend = 1'b1;
    tick(10);
    idle(2);
    check(8'(n_free), 8'h00);
    tick(1);
    idle(2);
    pend = 1'b0;
    check({busy, 3'(n_free), 4'(n_go)}, 8'h11);
    far.start_cond();
    idle(8);
    check(8'(busy), 8'h01);
    far.stop_cond();
    idle(8);
    check(8'(busy), 8'h00);
    sfr(1'b1, 8'hC1, 8'h00, 8'h88);
    idle(2);
    check({rl_hi, rl_lo}, 8'h03);
    split = 1'b1;
    idle(3);
    check({rl_hi, rl_lo}, 8'h02);
    far.step(1'b0, 1'b1);
    idle(8);
    check({rl_hi, rl_lo}, 8'h00);
    far.step(1'b1, 1'b1);
    sfr(1'b1, 8'hC1, 8'h00, 8'h00);
    idle(2);
    check({en, 3'(n_rst), setup}, 8'h11);
    check(hold, 8'h03);
    check(8'(n_hold), 8'h09);
    final_report();
  end
endmodule
